// file: hdl/pmcc_control.sv
// Conversion sequencing and digital outputs of the panel meter.

// What this block does
// [RL1] Internal trigger about ten times per second
// [RL2] Rate component absent: about twice per second
// [RL3] Busy input low suppresses internal triggering
// [RL4] External trigger: idle high, short low pulse
// [RL5] Trigger fall resets, rise starts conversion
// [RL6] External triggers no faster than sixty hertz
// [RL7] Conversion level high only while converting
// [RL8] One 75 us high completion pulse
// [RL9] Complementary low pulse, same time, same width
// [RL10] Parallel BCD digits, high means one
// [RL11] Decade ranges show 1.000 at full scale
// [RL12] Two ranges: leading one, rest blanked
// [RL13] Five ranges show .500 at full scale
// [RL14] Minus sign only for negative readings
// [RL15] Range follows panel selector unless remote
// [RL16] Busy low freezes the output data of internally triggered conversions
// [RL17] Overload outputs high during overload
// [RL18] Data settles before completion pulse rises
module pmcc_control
  import pmcc_pkg::*;
#(
  parameter int PERIOD_NOM  = pmcc_pkg::PERIOD_NOM_CYC,
  parameter int PERIOD_SLOW = pmcc_pkg::PERIOD_SLOW_CYC,
  parameter int CONV_LEN    = pmcc_pkg::CONV_CYC,
  parameter int PULSE_LEN   = pmcc_pkg::PULSE_CYC
)
(
  // Clock, reset and enable.
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // Connector pins from the external system.
  input  wire logic                      not_busy_pin,
  input  wire logic                      ext_trigger_pin,
  // Board straps and front panel.
  input  wire logic                      rate_component_fitted,
  input  wire logic [1:0]                panel_range,
  // Remote sensitivity control, same clock.
  input  wire logic                      remote_active,
  input  wire pmcc_pkg::pmcc_range_type  remote_range,
  // Converter sample, same clock.
  input  wire pmcc_pkg::pmcc_sample_type sample,
  // Conversion status outputs.
  output logic                           conversion_active_level,
  output logic                           conversion_done,
  output logic                           conversion_done_n,
  // Reading outputs.
  output pmcc_pkg::pmcc_reading_type     reading
);
  import pmcc_pkg::*;

  // ****************************************************************
  // Reading formatter
  // ****************************************************************

  // Binary to four BCD digits by shift and add three.
  function automatic logic [3:0][3:0] to_bcd(input logic [DISP_W-1:0] v);
    logic [15:0] acc;
    acc = '0;
    for (int i = DISP_W - 1; i >= 0; i--)
    begin
      for (int d = 0; d < 4; d++)
      begin
        if (acc[d*4 +: 4] > 4'h4)
        begin
          acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
        end
      end
      acc = {acc[14:0], v[i]};
    end
    return acc;
  endfunction

  // Scales a sample for the range kind and lays out the display.
  function automatic pmcc_reading_type format(input pmcc_sample_type s,
                                              input pmcc_range_type k);
    pmcc_reading_type   f;
    logic [DISP_W-1:0]  disp;
    f    = '0;
    disp = {1'b0, s.counts};                             // [RL11]
    if (k == RANGE_FIVE)
    begin
      disp = {2'b00, s.counts[COUNT_W-1:1]};             // [RL13]
    end
    else if (k == RANGE_TWO)
    begin
      disp = {s.counts, 1'b0};                           // [RL12]
    end
    f.minus    = s.negative;                             // [RL14]
    f.positive = ~s.negative;
    f.overload = (disp > DISP_MAX);                      // [RL17]
    f.blank    = f.overload;                             // [RL12]
    f.digits   = to_bcd(disp);                           // [RL10]
    if (f.blank)
    begin
      f.digits = {LEAD_ONE, BLANK_DIGIT, BLANK_DIGIT, BLANK_DIGIT};
    end
    return f;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  pmcc_state_type     r;
  pmcc_state_type     next_r;
  logic               trig_fall;
  logic               trig_rise;
  logic [TIMER_W-1:0] period_last;
  pmcc_range_type     range_kind;

  // Edge detection works on the settled trigger only.
  assign trig_fall   = r.trig_d & ~r.trig_s;
  assign trig_rise   = ~r.trig_d & r.trig_s;
  assign period_last = r.rate_s ? TIMER_W'(PERIOD_NOM - 1)   // [RL1]
                                : TIMER_W'(PERIOD_SLOW - 1); // [RL2]
  // Remote control overrides the panel selector.
  assign range_kind  = remote_active ? remote_range
                                     : pmcc_range_type'(r.panel_s); // [RL15]

  // Next state: synchronisers, trigger sequencer and output latch.
  always_comb
  begin
    next_r         = r;
    next_r.busy_m  = not_busy_pin;
    next_r.busy_s  = r.busy_m;
    next_r.trig_m  = ext_trigger_pin;
    next_r.trig_s  = r.trig_m;
    next_r.trig_d  = r.trig_s;
    next_r.rate_m  = rate_component_fitted;
    next_r.rate_s  = r.rate_m;
    next_r.panel_m = panel_range;
    next_r.panel_s = r.panel_m;
    if (r.period < period_last)
    begin
      next_r.period = r.period + TIMER_W'(1);
    end
    unique case (r.phase)
      ST_IDLE:
      begin
        if (r.busy_s && r.period >= period_last)          // [RL1] [RL3]
        begin
          next_r.phase  = ST_CONVERT;
          next_r.timer  = '0;
          next_r.period = '0;
          next_r.ext    = 1'b0;
        end
      end
      ST_ARMED:
      begin
        if (trig_rise)                                    // [RL5]
        begin
          next_r.phase = ST_CONVERT;
          next_r.timer = '0;
          next_r.ext   = 1'b1;
        end
      end
      ST_CONVERT:
      begin
        next_r.timer = r.timer + TIMER_W'(1);
        // Latch one cycle before the pulse so data is settled.
        if (r.timer == TIMER_W'(CONV_LEN - 2) && (r.busy_s || r.ext))
        begin
          next_r.reading = format(sample, range_kind);    // [RL16] [RL18]
        end
        if (r.timer == TIMER_W'(CONV_LEN - 1))
        begin
          next_r.phase = ST_PULSE;                        // [RL7] [RL8]
          next_r.timer = '0;
        end
      end
      ST_PULSE:
      begin
        next_r.timer = r.timer + TIMER_W'(1);
        if (r.timer == TIMER_W'(PULSE_LEN - 1))           // [RL8]
        begin
          next_r.phase = ST_IDLE;
          next_r.timer = '0;
          if (r.pend || trig_fall)
          begin
            // A trigger seen during the pulse is served now.
            next_r.pend  = 1'b0;
            next_r.phase = r.trig_s ? ST_CONVERT : ST_ARMED;
            next_r.ext   = 1'b1;
          end
        end
        else if (trig_fall)
        begin
          next_r.pend = 1'b1;
        end
      end
    endcase
    // A falling trigger resets the converter, except mid pulse.
    if (trig_fall && r.phase != ST_PULSE)                 // [RL5]
    begin
      next_r.phase = ST_ARMED;
      next_r.timer = '0;
    end
    if (!clk_en)
    begin
      next_r = r;
    end
  end

  // Registers the whole state.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= PMCC_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Status levels follow the phase register directly.
  assign conversion_active_level = (r.phase == ST_CONVERT);  // [RL7]
  assign conversion_done         = (r.phase == ST_PULSE);    // [RL8]
  assign conversion_done_n       = ~conversion_done;         // [RL9]
  assign reading                 = r.reading;

  // ****************************************************************
  // Checks
  // ****************************************************************

  property p_done_after_conv;
    @(posedge clk) disable iff (!rst_n)
    $rose(conversion_done) |->
      $past(conversion_active_level) && !conversion_active_level
      && $past(r.timer) == TIMER_W'(CONV_LEN - 1);
  endproperty
  a_done_after_conv: assert property (p_done_after_conv) // [RL7]
    else $error("Completion pulse not at conversion_active_level.");
  property p_pulse_width;
    @(posedge clk) disable iff (!rst_n)
    $fell(conversion_done) |-> $past(r.timer) == TIMER_W'(PULSE_LEN - 1);
  endproperty
  a_pulse_width: assert property (p_pulse_width) // [RL8]
    else $error("Completion pulse has the wrong width.");
  // The low pulse must open with the high one and stay low for three more cycles.
  property p_pulse_pair;
    @(posedge clk) disable iff (!rst_n)
    $rose(conversion_done) |-> $fell(conversion_done_n)
      ##1 (!conversion_done_n)[*3];
  endproperty
  a_pulse_pair: assert property (p_pulse_pair) // [RL9]
    else $error("Complementary pulse does not match.");
  property p_data_settled;
    @(posedge clk) disable iff (!rst_n)
    conversion_done |-> $stable(reading);
  endproperty
  a_data_settled: assert property (p_data_settled) // [RL18]
    else $error("Reading changed during completion pulse.");
  property p_busy_inhibits;
    @(posedge clk) disable iff (!rst_n)
    r.phase == ST_IDLE && !r.busy_s && r.trig_s |=> r.phase != ST_CONVERT;
  endproperty
  a_busy_inhibits: assert property (p_busy_inhibits) // [RL3]
    else $error("Internal trigger while busy input low.");
  property p_fall_resets;
    @(posedge clk) disable iff (!rst_n)
    clk_en && trig_fall && r.phase != ST_PULSE |=> r.phase == ST_ARMED;
  endproperty
  a_fall_resets: assert property (p_fall_resets) // [RL5]
    else $error("Trigger fall did not reset the converter.");
  property p_rise_starts;
    @(posedge clk) disable iff (!rst_n)
    clk_en && r.phase == ST_ARMED && trig_rise |=> conversion_active_level;
  endproperty
  a_rise_starts: assert property (p_rise_starts) // [RL5]
    else $error("Trigger rise did not start a conversion.");
  // A strap change may leave the count above a new, shorter limit.
  property p_period_bound;
    @(posedge clk) disable iff (!rst_n)
    r.period >= period_last |=> $stable(r.period) || r.period == '0;
  endproperty
  a_period_bound: assert property (p_period_bound) // [RL2]
    else $error("Trigger period counter overran its limit.");
  property p_overload_blank;
    @(posedge clk) disable iff (!rst_n)
    reading.overload |-> reading.blank && reading.digits[3] == LEAD_ONE
      && reading.digits[0] == BLANK_DIGIT;
  endproperty
  a_overload_blank: assert property (p_overload_blank) // [RL12]
    else $error("Over-range reading not blanked.");
  property p_sign;
    @(posedge clk) disable iff (!rst_n)
    reading.minus == !reading.positive;
  endproperty
  a_sign: assert property (p_sign) // [RL14]
    else $error("Sign outputs disagree.");
endmodule

// file: hdl/pmcc_pkg.sv
// Constants, types and state layout of the panel meter conversion control.
package pmcc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ         = 200;
  localparam int RATE_NOM_MS     = 100;  // About ten conversions a second.
  localparam int RATE_SLOW_MS    = 500;  // About two a second, no component.
  localparam int CONV_MS         = 40;   // Length of one conversion.
  localparam int PULSE_US        = 75;   // Completion pulse width.
  localparam int US_CYC          = CLK_MHZ;
  localparam int MS_CYC          = 1000 * US_CYC;
  localparam int PERIOD_NOM_CYC  = RATE_NOM_MS * MS_CYC;
  localparam int PERIOD_SLOW_CYC = RATE_SLOW_MS * MS_CYC;
  localparam int CONV_CYC        = CONV_MS * MS_CYC;
  localparam int PULSE_CYC       = PULSE_US * US_CYC;
  localparam int TIMER_W         = 32;

  // ****************************************************************
  // Display
  // ****************************************************************
  localparam int COUNT_W = 12;
  localparam int DISP_W  = 13;
  localparam logic [DISP_W-1:0] DISP_MAX    = 13'h07cf; // 1999 counts.
  localparam logic [3:0]        BLANK_DIGIT = 4'hf;
  localparam logic [3:0]        LEAD_ONE    = 4'h1;

  typedef enum logic [1:0] {RANGE_ONE, RANGE_TWO, RANGE_FIVE} pmcc_range_type;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONVERT, ST_PULSE}
    pmcc_phase_type;

  // One converted sample from the analog front end.
  typedef struct packed {
    logic               negative;
    logic [COUNT_W-1:0] counts;  // 1000 counts equal full scale.
  } pmcc_sample_type;

  // Reading presented at the digital output connector.
  typedef struct packed {
    logic            positive;  // High for a positive reading.
    logic            minus;     // High lights the minus sign.
    logic            overload;
    logic            blank;     // Point and three low digits dark.
    logic [3:0][3:0] digits;    // Index 3 is the most significant.
  } pmcc_reading_type;

  // Whole state of the control block.
  typedef struct packed {
    logic                 busy_m;
    logic                 busy_s;
    logic                 trig_m;
    logic                 trig_s;
    logic                 trig_d;
    logic                 rate_m;
    logic                 rate_s;
    logic [1:0]           panel_m;
    logic [1:0]           panel_s;
    pmcc_phase_type       phase;
    logic                 ext;
    logic                 pend;
    logic [TIMER_W-1:0]   timer;
    logic [TIMER_W-1:0]   period;
    pmcc_reading_type     reading;
  } pmcc_state_type;

  localparam pmcc_state_type PMCC_RESET = '{
    busy_m: 1'b0, busy_s: 1'b0, trig_m: 1'b1, trig_s: 1'b1, trig_d: 1'b1,
    rate_m: 1'b1, rate_s: 1'b1, panel_m: 2'h0, panel_s: 2'h0,
    phase: ST_IDLE, ext: 1'b0, pend: 1'b0, timer: '0, period: '0,
    reading: '{positive: 1'b1, minus: 1'b0, overload: 1'b0, blank: 1'b0,
               digits: '0}};

endpackage

// file: tb/pmcc_host_model.sv
// Model of the external digital system on the meter's output connector.
module pmcc_host_model
  import pmcc_pkg::*;
(
  // Clock.
  input  wire logic                       clk,
  // Status and reading from the meter.
  input  wire logic                       conversion_done,
  input  wire logic                       conversion_done_n,
  input  wire pmcc_pkg::pmcc_reading_type reading,
  // Connector pins toward the meter.
  output logic                            not_busy_pin,
  output logic                            ext_trigger_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  pmcc_reading_type latched;
  pmcc_reading_type latched_n;

  // Both pins idle high: not busy and no trigger request.
  initial
  begin
    not_busy_pin    = 1'b1;
    ext_trigger_pin = 1'b1;
  end

  // The digits are latched on either edge that opens the completion pulse.
  always @(posedge conversion_done) latched = reading;
  always @(negedge conversion_done_n) latched_n = reading;

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Holds the busy line; low keeps the meter from triggering itself.
  task automatic set_busy(input logic level);
    @(negedge clk);
    not_busy_pin = level;
  endtask

  // One low pulse; a run sends a single one, far below the rate limit.
  task automatic trigger(input int low_cyc);
    @(negedge clk);
    ext_trigger_pin = 1'b0;
    repeat (low_cyc) @(negedge clk);
    ext_trigger_pin = 1'b1;
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking testbench of the panel meter conversion control.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pmcc_pkg::*;

  localparam int P_NOM  = 60;
  localparam int P_SLOW = 150;
  localparam int C_LEN  = 20;
  localparam int P_LEN  = 6;

  logic             clk;
  logic             rst_n;
  logic             clk_en;
  logic             nbusy;
  logic             trig;
  logic             rate_fit;
  logic [1:0]       panel;
  logic             rem;
  pmcc_range_type   rem_rng;
  pmcc_sample_type  sample;
  logic             act;
  logic             done;
  logic             done_n;
  pmcc_reading_type reading;
  int               err_count;
  int               n_compared;

  pmcc_control #(.PERIOD_NOM(P_NOM), .PERIOD_SLOW(P_SLOW),
    .CONV_LEN(C_LEN), .PULSE_LEN(P_LEN)) u_pmcc_control (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .not_busy_pin(nbusy),
    .ext_trigger_pin(trig), .rate_component_fitted(rate_fit),
    .panel_range(panel), .remote_active(rem), .remote_range(rem_rng),
    .sample(sample), .conversion_active_level(act),
    .conversion_done(done), .conversion_done_n(done_n), .reading(reading));

  pmcc_host_model u_pmcc_host_model (
    .clk(clk), .conversion_done(done), .conversion_done_n(done_n),
    .reading(reading), .not_busy_pin(nbusy), .ext_trigger_pin(trig));

  // Clock of 5 ns period.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One cycle of waiting; a wait that runs too long ends the run.
  task automatic tick(inout int k);
    @(negedge clk);
    k++;
    if (k > 2000)
    begin
      err_count++;
      end_sim();
    end
  endtask

  // Builds an expected reading; overload also darkens the low digits.
  function automatic pmcc_reading_type rd(input logic neg, input logic ovl,
                                          input logic [15:0] d);
    rd = '{positive: !neg, minus: neg, overload: ovl, blank: ovl, digits: d};
  endfunction

  // Follows one conversion; a nonzero gap also times the next start.
  task automatic conv(input int gap, input pmcc_reading_type exp,
                      output int w);
    int n;
    int t;
    pmcc_reading_type hold;
    w = 0;
    n = 0;
    t = 0;
    while (act !== 1'b0) tick(w);
    while (act !== 1'b1) tick(w);
    while (act === 1'b1) tick(n);
    check(n, C_LEN);
    hold = reading;
    check(reading, exp);
    while (done === 1'b1)
    begin
      check(done_n, 1'b0);
      check(reading, hold);
      tick(t);
    end
    check(t, P_LEN);
    check(done_n, 1'b1);
    check(u_pmcc_host_model.latched, exp);
    check(u_pmcc_host_model.latched_n, exp);
    if (gap != 0)
    begin
      while (act !== 1'b1) tick(n);
      check(n + t, gap);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Nominal rate, full scale and above it on a decade range.
  task automatic sc_internal();
    int w;
    conv(0, rd(0, 0, 16'h1000), w);
    conv(P_NOM, rd(0, 0, 16'h1000), w);
    sample.counts = 12'h05dc;
    conv(P_NOM, rd(0, 0, 16'h1500), w);
    sample.counts = 12'h07cf;
    conv(0, rd(0, 0, 16'h1999), w);
  endtask

  // Rate component absent stretches the period.
  task automatic sc_slow();
    int w;
    rate_fit = 1'b0;
    conv(0, rd(0, 0, 16'h1999), w);
    conv(P_SLOW, rd(0, 0, 16'h1999), w);
    rate_fit = 1'b1;
    conv(0, rd(0, 0, 16'h1999), w);
  endtask

  // Two range at full scale, chosen by remote and then by the panel.
  task automatic sc_ranges();
    int w;
    rem = 1'b1;
    rem_rng = RANGE_TWO;
    sample.counts = 12'h03e8;
    conv(0, rd(0, 1, 16'h1fff), w);
    rem = 1'b0;
    panel = 2'h1;
    conv(0, rd(0, 1, 16'h1fff), w);
    rem = 1'b1;
    rem_rng = RANGE_ONE;
    conv(0, rd(0, 0, 16'h1000), w);
    rem = 1'b0;
    panel = 2'h0;
  endtask

  // Clock enable low for ten cycles stretches a running conversion.
  task automatic sc_freeze();
    int n;
    n = 0;
    while (act !== 1'b1) tick(n);
    clk_en = 1'b0;
    repeat (10) tick(n);
    check(act, 1'b1);
    check(done, 1'b0);
    clk_en = 1'b1;
    n = 0;
    while (act === 1'b1) tick(n);
    check(n, C_LEN);
  endtask

  // Busy low stops internal starts and freezes the reading.
  task automatic sc_busy();
    int r;
    pmcc_reading_type hold;
    r = 0;
    hold = reading;
    u_pmcc_host_model.set_busy(1'b0);
    sample.counts = 12'h05dc;
    repeat (3 * P_SLOW)
    begin
      @(negedge clk);
      if (act !== 1'b0)
        r++;
    end
    check(r, 0);
    check(reading, hold);
  endtask

  // External trigger: start follows the rising edge, five range, negative.
  task automatic sc_external();
    int w;
    panel = 2'h2;
    sample = '{negative: 1'b1, counts: 12'h03e8};
    fork
      u_pmcc_host_model.trigger(300);
      conv(0, rd(1, 0, 16'h0500), w);
    join
    check(w > 300 && w < 308, 1'b1);
    u_pmcc_host_model.set_busy(1'b1);
  endtask

  // Reset for four cycles, then the scenarios in turn.
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    rate_fit = 1'b1;
    panel = 2'h0;
    rem = 1'b0;
    rem_rng = RANGE_ONE;
    sample = '{negative: 1'b0, counts: 12'h03e8};
    err_count = 0;
    n_compared = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    sc_internal();
    sc_slow();
    sc_ranges();
    sc_freeze();
    sc_busy();
    sc_external();
    end_sim();
  end
endmodule
